// ### src/tic_top.sv
// Timer interrupt control and clear registers on an AHB-Lite slave
// Assumes single-word transfers, hready from this slave only
`timescale 1ns/100ps
module tic_top
  import tic_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [3:0]  ev_a,
  input  wire logic [3:0]  ev_b,
  output logic             timer_irq,
  output logic             sys_irq
);
  tic_flag_if flg ();

  tic_phase_t  ph_q;
  tic_phase_t  ph_d;
  logic [11:0] adr_q;
  logic [11:0] adr_d;
  logic        wr_q;
  logic        wr_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [3:0]  ien_q;
  logic [3:0]  ien_d;
  tic_mode_t   mode_q;
  tic_mode_t   mode_d;
  logic [1:0]  sts_q;
  logic [1:0]  sts_d;
  logic [1:0]  msk_q;
  logic [1:0]  msk_d;
  logic [3:0]  cond;
  logic [3:0]  pnd_prev_q;
  logic [3:0]  pnd_prev_d;
  logic        addr_ok;
  logic        rd_now;
  logic        wr_now;
  logic        wr_ctrl;
  logic        wr_clr;
  logic [1:0]  ev_sts;

  tic_flag_bank u_bank (
    .clk   (clk),
    .reset (reset),
    .flg   (flg.bank)
  );

  tic_mode_select u_mode (
    .clk   (clk),
    .reset (reset),
    .mode  (mode_q),
    .ev_a  (ev_a),
    .ev_b  (ev_b),
    .cond  (cond)
  );

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel && hready && htrans[1];

  // Address phase capture and register reads
  always_comb begin
    ph_d    = addr_ok ? TIC_PH_DATA : TIC_PH_IDLE;
    adr_d   = addr_ok ? haddr : adr_q;
    wr_d    = addr_ok ? hwrite : 1'b0;
    rd_now  = addr_ok && !hwrite;
    rdata_d = rdata_q;
    if (rd_now) begin
      if (haddr == OFS_CONTROL) begin
        rdata_d = {24'h00_0000, ien_q, flg.pending};
      end else if (haddr == OFS_CLEAR) begin
        rdata_d = {24'h00_0000, CLEAR_READ};
      end else if (haddr == OFS_STATUS) begin
        rdata_d = {30'h0000_0000, sts_q};
      end else if (haddr == OFS_MASK) begin
        rdata_d = {30'h0000_0000, msk_q};
      end else if (haddr == OFS_MODE) begin
        rdata_d = {30'h0000_0000, mode_q};
      end else begin
        rdata_d = 32'h0000_0000;
      end
    end
  end

  assign wr_now  = (ph_q == TIC_PH_DATA) && wr_q;
  assign wr_ctrl = wr_now && (adr_q == OFS_CONTROL);
  assign wr_clr  = wr_now && (adr_q == OFS_CLEAR);

  // Pending flag drive: hardware, software set, clear register
  always_comb begin
    flg.set_vec    = cond;
    flg.sw_set_vec = wr_ctrl ? hwdata[PND_LSB +: 4] : 4'h0;
    flg.clr_vec    = wr_clr ? hwdata[3:0] : 4'h0;
  end

  // Control, mode, mask and status state
  always_comb begin
    ien_d  = wr_ctrl ? hwdata[IEN_LSB +: 4] : ien_q;
    mode_d = (wr_now && adr_q == OFS_MODE) ?
             tic_mode_t'(hwdata[1:0]) : mode_q;
    msk_d  = (wr_now && adr_q == OFS_MASK) ? hwdata[1:0] : msk_q;
    pnd_prev_d = flg.pending;
    ev_sts[0]  = |(flg.pending & ~pnd_prev_q);
    ev_sts[1]  = |(flg.clr_vec & flg.pending);
    sts_d = sts_q;
    if (rd_now && haddr == OFS_STATUS) begin
      sts_d = 2'h0;
    end
    sts_d = sts_d | ev_sts;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ph_q       <= TIC_PH_IDLE;
      adr_q      <= 12'h000;
      wr_q       <= 1'b0;
      rdata_q    <= 32'h0000_0000;
      ien_q      <= CONTROL_RST[7:4];
      mode_q     <= TIC_MODE_PWM;
      msk_q      <= MASK_RST;
      sts_q      <= STATUS_RST;
      pnd_prev_q <= 4'h0;
    end else begin
      ph_q       <= ph_d;
      adr_q      <= adr_d;
      wr_q       <= wr_d;
      rdata_q    <= rdata_d;
      ien_q      <= ien_d;
      mode_q     <= mode_d;
      msk_q      <= msk_d;
      sts_q      <= sts_d;
      pnd_prev_q <= pnd_prev_d;
    end
  end

  assign hrdata    = rdata_q;
  assign timer_irq = |(flg.pending & ien_q);
  assign sys_irq   = |(sts_q & msk_q);
endmodule // tic_top

// ### src/tic_pkg.sv
// Constants for the timer interrupt pending and clear logic
// Assumes an AHB-Lite register bus and a 25 MHz system clock
package tic_pkg;
  localparam int unsigned NUM_SRC = 4;
  localparam logic [11:0] OFS_CONTROL = 12'h000;
  localparam logic [11:0] OFS_CLEAR   = 12'h004;
  localparam logic [11:0] OFS_STATUS  = 12'h008;
  localparam logic [11:0] OFS_MASK    = 12'h00C;
  localparam logic [11:0] OFS_MODE    = 12'h010;
  localparam logic [7:0]  CONTROL_RST = 8'h00;
  localparam logic [7:0]  CLEAR_READ  = 8'hFF;
  localparam logic [1:0]  MODE_RST    = 2'h0;
  localparam logic [1:0]  STATUS_RST  = 2'h0;
  localparam logic [1:0]  MASK_RST    = 2'h0;
  localparam int unsigned PND_LSB = 0;
  localparam int unsigned IEN_LSB = 4;
  typedef enum logic [1:0] {
    TIC_MODE_PWM,
    TIC_MODE_CAPTURE,
    TIC_MODE_DUAL,
    TIC_MODE_SINGLE
  } tic_mode_t;
  typedef enum logic [0:0] {
    TIC_PH_IDLE,
    TIC_PH_DATA
  } tic_phase_t;
endpackage

// ### src/tic_flag_if.sv
// Interface carrying pending flags between core and flag bank
// Assumes one clock domain
`timescale 1ns/100ps
interface tic_flag_if;
  logic [3:0] set_vec;
  logic [3:0] clr_vec;
  logic [3:0] sw_set_vec;
  logic [3:0] pending;
  modport bank (input set_vec, input clr_vec, input sw_set_vec,
                output pending);
  modport ctrl (output set_vec, output clr_vec, output sw_set_vec,
                input pending);
endinterface

// ### src/tic_flag_bank.sv
// Four sticky pending flags with set-over-clear priority
// Assumes set and clear vectors synchronous to clk
`timescale 1ns/100ps
module tic_flag_bank
  import tic_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  tic_flag_if.bank  flg
);
  logic [3:0] pnd_q;
  logic [3:0] pnd_d;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_flag
      always_comb begin
        if (flg.set_vec[g] || flg.sw_set_vec[g]) begin
          pnd_d[g] = 1'b1;
        end else if (flg.clr_vec[g]) begin
          pnd_d[g] = 1'b0;
        end else begin
          pnd_d[g] = pnd_q[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pnd_q <= CONTROL_RST[3:0];
    end else begin
      pnd_q <= pnd_d;
    end
  end

  assign flg.pending = pnd_q;
endmodule // tic_flag_bank

// ### src/tic_mode_select.sv
// Picks the event that raises each source flag for the mode
// Assumes single-cycle event pulses from the timer core
`timescale 1ns/100ps
module tic_mode_select
  import tic_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire tic_mode_t  mode,
  input  wire logic [3:0] ev_a,
  input  wire logic [3:0] ev_b,
  output logic      [3:0] cond
);
  logic [3:0] cond_d;

  always_comb begin
    case (mode)
      TIC_MODE_PWM:     cond_d = ev_a;
      TIC_MODE_CAPTURE: cond_d = ev_b;
      TIC_MODE_DUAL:    cond_d = ev_a | ev_b;
      default:          cond_d = {ev_b[3:2], ev_a[1:0]};
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cond <= 4'h0;
    end else begin
      cond <= cond_d;
    end
  end
endmodule // tic_mode_select

// ### verif/tic_top_props.sv
// Checker for the timer interrupt register slave
// Sees only tic_top ports; one clock domain
`timescale 1ns/100ps
module tic_top_props
  import tic_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [3:0]  ev_a,
  input wire logic [3:0]  ev_b,
  input wire logic        timer_irq,
  input wire logic        sys_irq
);
  logic tx;
  logic rd;
  logic wr;
  assign tx = hsel & hready & htrans[1];
  assign rd = tx & !hwrite;
  assign wr = tx & hwrite;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus stall or error");
  property p_rst; $fell(reset) |-> !timer_irq && hrdata == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("not clear after reset");
  property p_clr_rd; rd && haddr == OFS_CLEAR |=> hrdata == 32'h0000_00FF;
  endproperty
  a_clr_rd: assert property (p_clr_rd) else $error("clear read bad");
  property p_ctl_rd; rd && haddr == OFS_CONTROL |=> hrdata[31:8] == 24'h0;
  endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("control wide");
  property p_unmap; rd && haddr > OFS_MODE |=> hrdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_hold; !rd |=> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_rise;
    $rose(timer_irq) |-> $past(ev_a | ev_b, 2) != 4'h0 || $past(wr, 2);
  endproperty
  a_rise: assert property (p_rise) else $error("irq without cause");
  property p_fall; $fell(timer_irq) |-> $past(wr, 2); endproperty
  a_fall: assert property (p_fall) else $error("irq dropped alone");
endmodule // tic_top_props
bind tic_top tic_top_props u_props (.clk(clk), .reset(reset), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .ev_a(ev_a), .ev_b(ev_b), .timer_irq(timer_irq),
  .sys_irq(sys_irq));

// ### verif/tb_timer_irq_pending_clear_logic.sv
// Self-checking bench for the timer interrupt register slave
// Drives tic_top over AHB-Lite single word transfers
`timescale 1ns/100ps
module tb_timer_irq_pending_clear_logic;
  import tic_pkg::*;
  logic        clk = 0, reset = 1, hsel = 0, hwrite = 0;
  logic [11:0] haddr = 0;
  logic [1:0]  htrans = 0;
  logic [31:0] hwdata = 0, hrdata, r;
  logic [3:0]  ev_a = 0, ev_b = 0;
  logic        hreadyout, hresp, timer_irq, sys_irq;
  logic [7:0]  exp_m [4] = '{8'h05, 8'h0A, 8'h0F, 8'h09};
  int          error_cnt = 0, samples_checked = 0;
  tic_top dut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ev_a(ev_a), .ev_b(ev_b), .timer_irq(timer_irq),
    .sys_irq(sys_irq));
  initial forever #20 clk = ~clk;
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge clk); hsel <= 1; haddr <= a; htrans <= 2'b10; hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 0; htrans <= 2'b00; hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic pulse(input logic [3:0] a, input logic [3:0] b);
    @(posedge clk); ev_a <= a; ev_b <= b;
    @(posedge clk); ev_a <= 4'h0; ev_b <= 4'h0;
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test;
    if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset <= 0;
    xfer(0, OFS_CONTROL, 0);
    chk("control", r, 32'h0000_0000);
    xfer(0, OFS_CLEAR, 0);
    chk("clear", r, 32'h0000_00FF);
    xfer(0, 12'h020, 0);
    chk("unmapped", r, 32'h0000_0000);
    for (int m = 0; m < 4; m++) begin
      xfer(1, OFS_MODE, 32'(m));
      pulse(4'h5, 4'hA);
      xfer(0, OFS_CONTROL, 0);
      chk("mode", r, {24'h00_0000, exp_m[m]});
      chk("irq off", {31'h0, timer_irq}, 32'h0);
      xfer(1, OFS_CLEAR, 32'h0000_00FF);
    end
    xfer(1, OFS_CONTROL, 32'h0000_0010);
    pulse(4'h2, 4'h0);
    xfer(0, OFS_CONTROL, 0);
    chk("flag b", r, 32'h0000_0012);
    chk("irq b", {31'h0, timer_irq}, 32'h0);
    xfer(1, OFS_CONTROL, 32'h0000_00F0);
    pulse(4'hF, 4'hF);
    xfer(1, OFS_CLEAR, 32'h0000_00F0);
    xfer(0, OFS_CONTROL, 0);
    chk("keep", r, 32'h0000_00FF);
    for (int i = 0; i < 4; i++) begin
      chk("irq on", {31'h0, timer_irq}, 32'h1);
      xfer(1, OFS_CLEAR, 32'h1 << i);
      xfer(0, OFS_CONTROL, 0);
      chk("drop", r, {24'h0, 4'hF, 4'(4'hF << (i + 1))});
    end
    chk("irq done", {31'h0, timer_irq}, 32'h0);
    xfer(0, OFS_STATUS, 0);
    chk("status all", r, 32'h0000_0003);
    xfer(1, OFS_MASK, 32'h0000_0001);
    @(posedge clk);
    chk("sys idle", {31'h0, sys_irq}, 32'h0);
    pulse(4'h1, 4'h0);
    xfer(0, OFS_MODE, 0);
    chk("mode rd", r, 32'h0000_0003);
    chk("sys on", {31'h0, sys_irq}, 32'h1);
    xfer(0, OFS_STATUS, 0);
    chk("status", r, 32'h0000_0001);
    @(posedge clk);
    chk("sys off", {31'h0, sys_irq}, 32'h0);
    finish_test;
  end
  initial begin
    #100000;
    error_cnt++;
    finish_test;
  end
endmodule // tb_timer_irq_pending_clear_logic
